// ==== dv/gpo_and_misc_control_regs_tb_top.sv ====
// Self-checking testbench for the general output and control register bank
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module gpo_and_misc_control_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0] pstrb, pci_int_n;
  logic [4:0] mf_is_output;
  gmcr_pkg::gmcr_pins_t mf_pins;
  logic host_supply_5v, aux_supply_3v3, cmd_start, cmd_strobe, rd_err;
  logic serirq_enable, int_via_serirq, dev_int, serirq_include_int;
  logic video_busy, video_activity, socket_busy, socket_led;
  logic sclk_en_drive, sclk_en_out, sclk_en_oe_n;
  logic [12:0] diag_test;
  int n_errors = 0;
  int checked = 0;
  integer seed = 32'hd4e5;
  int mdl [3];
  logic [31:0] msk [3];
  logic [11:0] adr [3];
  int wid [4];

  gmcr_regs u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .mf_is_output, .mf_pins, .host_supply_5v,
    .aux_supply_3v3, .cmd_start, .cmd_strobe, .serirq_enable,
    .int_via_serirq, .dev_int, .serirq_include_int, .pci_int_n,
    .video_busy, .video_activity, .socket_busy, .socket_led,
    .sclk_en_drive, .sclk_en_out, .sclk_en_oe_n, .diag_test
  );

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    #100000;
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Bus tasks and model
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    `CHK(pready, 1'b1)
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apb(1'b1, adr[i], d, s);
    mdl[i] = int'(((mdl[i] & ~bm) | (d & bm)) & msk[i]);
  endtask

  task automatic rd(input int i);
    apb(1'b0, adr[i], 32'h0, 4'h0);
    `CHK(rd_data, mdl[i])
    `CHK(rd_err, 1'b0)
  endtask

  task automatic chk_outs();
    logic [3:0] r;
    r = 4'hf;
    if (mdl[1][12] == 1'b0) r[mdl[1][11:10]] = 1'b0;
    `CHK(mf_pins.oe_n, ~mf_is_output)
    `CHK(mf_pins.level, mdl[0][4:0] & mf_is_output)
    `CHK(host_supply_5v, mdl[1][23])
    `CHK(aux_supply_3v3, mdl[1][22])
    `CHK(serirq_include_int, mdl[1][16] & serirq_enable)
    if (!dev_int) `CHK(pci_int_n, 4'hf)
    else if (serirq_enable && int_via_serirq) `CHK(pci_int_n, r)
    else `CHK(pci_int_n, 4'hf)
    `CHK(video_activity, mdl[1][9] & video_busy)
    `CHK(socket_led, mdl[1][8] & socket_busy)
    `CHK(sclk_en_oe_n, ~mdl[2][13])
    if (mdl[2][13]) `CHK(sclk_en_out, sclk_en_drive)
    else `CHK(sclk_en_out, 1'b0)
    `CHK(diag_test, mdl[2][12:0])
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    {psel, penable, pwrite, cmd_start, serirq_enable, int_via_serirq,
     dev_int, video_busy, socket_busy, sclk_en_drive} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mf_is_output = 5'h00;
    presetn = 1'b0;
    adr = '{gmcr_pkg::GMCR_ADDR_GPO, gmcr_pkg::GMCR_ADDR_CTRL1,
            gmcr_pkg::GMCR_ADDR_CTRL2};
    msk = '{32'h0000_001f, 32'h00cd_1f00, 32'h0000_3fff};
    mdl = '{0, 0, 0};
    wid = '{21, 10, 5, 21};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) rd(i);
    chk_outs();
    // Unmapped address is refused and leaves registers alone
    apb(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
    `CHK(rd_err, 1'b1)
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    `CHK(rd_err, 1'b1)
    `CHK(rd_data, 32'h0)
    for (int i = 0; i < 3; i++) begin
      rd(i);
      wr(i, 32'hffff_ffff, 4'hf);
      rd(i);
    end
    repeat (2) @(posedge pclk);
    chk_outs();
    // Strobe width for each code, start held while busy
    for (int c = 0; c < 4; c++) begin
      wr(1, (mdl[1] & ~32'h000c_0000) | (c << 18), 4'hf);
      cmd_start <= 1'b1;
      n = 0;
      for (int k = 0; k < 45; k++) begin
        @(posedge pclk);
        if (cmd_strobe === 1'b1) n++;
        if (k == 2) cmd_start <= 1'b0;
      end
      `CHK(n, wid[c])
    end
    // Random traffic with random byte strobes and side inputs
    for (int k = 0; k < 60; k++) begin
      wr(k % 3, $random(seed), 4'($random(seed)));
      {mf_is_output, serirq_enable, int_via_serirq, dev_int, video_busy,
       socket_busy, sclk_en_drive} <= 11'($random(seed));
      rd((k + 1) % 3);
      repeat (2) @(posedge pclk);
      chk_outs();
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{0, 0, 0};
    repeat (2) @(posedge pclk);
    chk_outs();
    for (int i = 0; i < 3; i++) rd(i);
    report_and_stop();
  end
endmodule

// ==== rtl/gmcr_pkg.sv ====
// Package: register map, field layout and timing for the control bank
package gmcr_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] GMCR_IDX_GPO = 12'h0ae;
  localparam logic [11:0] GMCR_IDX_CTRL1 = 12'h0d0;
  localparam logic [11:0] GMCR_IDX_CTRL2 = 12'h0d4;
  localparam logic [11:0] GMCR_ADDR_GPO = 12'(GMCR_IDX_GPO * 4);
  localparam logic [11:0] GMCR_ADDR_CTRL1 = 12'(GMCR_IDX_CTRL1 * 4);
  localparam logic [11:0] GMCR_ADDR_CTRL2 = 12'(GMCR_IDX_CTRL2 * 4);

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GMCR_MASK_GPO = 32'h0000_001f;
  localparam logic [31:0] GMCR_MASK_CTRL1 = 32'h00cd_1f00;
  localparam logic [31:0] GMCR_MASK_CTRL2 = 32'h0000_3fff;
  localparam logic [31:0] GMCR_RST_GPO = 32'h0000_0000;
  localparam logic [31:0] GMCR_RST_CTRL1 = 32'h0000_0000;
  localparam logic [31:0] GMCR_RST_CTRL2 = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GMCR_POS_HOST_5V = 23;
  localparam int GMCR_POS_AUX_3V3 = 22;
  localparam int GMCR_POS_CMD_WIDTH = 18;
  localparam int GMCR_POS_INCL_INT = 16;
  localparam int GMCR_POS_INT_ROUTE = 10;
  localparam int GMCR_POS_VIDEO_EN = 9;
  localparam int GMCR_POS_SKT_EN = 8;
  localparam int GMCR_POS_SCLK_DIR = 13;
  localparam int GMCR_POS_DIAG = 0;
  localparam int GMCR_GPO_BITS = 5;

  // ----------------------------------------------------------------
  // Command strobe timing
  // ----------------------------------------------------------------
  localparam int GMCR_CLK_PERIOD_NS = 8;
  localparam int GMCR_CMD_165_NS = 165;
  localparam int GMCR_CMD_80_NS = 80;
  localparam int GMCR_CMD_40_NS = 40;
  localparam logic [4:0] GMCR_CMD_165_CYC =
    5'((GMCR_CMD_165_NS + GMCR_CLK_PERIOD_NS - 1) / GMCR_CLK_PERIOD_NS);
  localparam logic [4:0] GMCR_CMD_80_CYC =
    5'((GMCR_CMD_80_NS + GMCR_CLK_PERIOD_NS - 1) / GMCR_CLK_PERIOD_NS);
  localparam logic [4:0] GMCR_CMD_40_CYC =
    5'((GMCR_CMD_40_NS + GMCR_CLK_PERIOD_NS - 1) / GMCR_CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GMCR_W165 = 2'b00,
    GMCR_W80 = 2'b01,
    GMCR_W40 = 2'b10,
    GMCR_WRSV = 2'b11
  } gmcr_width_t;

  // Multifunction pin group, index 0..4 = pins 0,1,2,4,5
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe_n;
  } gmcr_pins_t;

endpackage

// ==== rtl/gmcr_regs.sv ====
// Module: general output and miscellaneous control register bank on APB
`timescale 1ns/10ps
module gmcr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [4:0] mf_is_output,
  output gmcr_pkg::gmcr_pins_t mf_pins,
  output logic host_supply_5v,
  output logic aux_supply_3v3,
  input wire logic cmd_start,
  output logic cmd_strobe,
  input wire logic serirq_enable,
  input wire logic int_via_serirq,
  input wire logic dev_int,
  output logic serirq_include_int,
  output logic [3:0] pci_int_n,
  input wire logic video_busy,
  output logic video_activity,
  input wire logic socket_busy,
  output logic socket_led,
  input wire logic sclk_en_drive,
  output logic sclk_en_out,
  output logic sclk_en_oe_n,
  output logic [12:0] diag_test
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] gmcr_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input logic [31:0] mask
  );
    logic [31:0] m;
    m = mask & {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wdata & m);
  endfunction

  function automatic logic [4:0] gmcr_width_cycles(input logic [1:0] code);
    logic [4:0] c;
    c = gmcr_pkg::GMCR_CMD_165_CYC;
    if (code == gmcr_pkg::GMCR_W80) begin
      c = gmcr_pkg::GMCR_CMD_80_CYC;
    end else if (code == gmcr_pkg::GMCR_W40) begin
      c = gmcr_pkg::GMCR_CMD_40_CYC;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [31:0] gpo;
  logic [31:0] ctrl1;
  logic [31:0] ctrl2;
  logic [4:0] cmd_count;

  wire sel_gpo = paddr == gmcr_pkg::GMCR_ADDR_GPO;
  wire sel_ctrl1 = paddr == gmcr_pkg::GMCR_ADDR_CTRL1;
  wire sel_ctrl2 = paddr == gmcr_pkg::GMCR_ADDR_CTRL2;
  wire mapped = sel_gpo | sel_ctrl1 | sel_ctrl2;
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready & pwrite & ~pslverr;

  // Reserved read zero
  // Masked readback
  wire [31:0] read_mux = sel_gpo ? gpo & gmcr_pkg::GMCR_MASK_GPO :
    sel_ctrl1 ? ctrl1 & gmcr_pkg::GMCR_MASK_CTRL1 :
    sel_ctrl2 ? ctrl2 & gmcr_pkg::GMCR_MASK_CTRL2 : 32'h0000_0000;

  wire [31:0] next_gpo = (commit & sel_gpo) ?
    gmcr_merge(gpo, pwdata, pstrb, gmcr_pkg::GMCR_MASK_GPO) : gpo;
  wire [31:0] next_ctrl1 = (commit & sel_ctrl1) ?
    gmcr_merge(ctrl1, pwdata, pstrb, gmcr_pkg::GMCR_MASK_CTRL1) : ctrl1;
  wire [31:0] next_ctrl2 = (commit & sel_ctrl2) ?
    gmcr_merge(ctrl2, pwdata, pstrb, gmcr_pkg::GMCR_MASK_CTRL2) : ctrl2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpo <= gmcr_pkg::GMCR_RST_GPO;
      ctrl1 <= gmcr_pkg::GMCR_RST_CTRL1;
      ctrl2 <= gmcr_pkg::GMCR_RST_CTRL2;
    end else begin
      gpo <= next_gpo;
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
    end
  end

  // ----------------------------------------------------------------
  // APB answer, no wait state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? read_mux : 32'h0000_0000;
      pslverr <= setup & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  wire [4:0] out_level = gpo[gmcr_pkg::GMCR_GPO_BITS-1:0];
  wire f_host_5v = ctrl1[gmcr_pkg::GMCR_POS_HOST_5V];
  wire f_aux_3v3 = ctrl1[gmcr_pkg::GMCR_POS_AUX_3V3];
  wire [1:0] f_cmd_width = ctrl1[gmcr_pkg::GMCR_POS_CMD_WIDTH +: 2];
  wire f_incl_int = ctrl1[gmcr_pkg::GMCR_POS_INCL_INT];
  wire [2:0] f_route = ctrl1[gmcr_pkg::GMCR_POS_INT_ROUTE +: 3];
  wire f_video_en = ctrl1[gmcr_pkg::GMCR_POS_VIDEO_EN];
  wire f_skt_en = ctrl1[gmcr_pkg::GMCR_POS_SKT_EN];
  wire f_sclk_dir = ctrl2[gmcr_pkg::GMCR_POS_SCLK_DIR];
  wire [12:0] f_diag = ctrl2[gmcr_pkg::GMCR_POS_DIAG +: 13];

  // ----------------------------------------------------------------
  // Pin and control outputs
  // ----------------------------------------------------------------
  // Pin levels from bits
  wire [4:0] next_pin_level = out_level & mf_is_output;
  wire [4:0] next_pin_oe_n = ~mf_is_output;

  wire route_on = serirq_enable & int_via_serirq;
  wire [3:0] route_hot = (f_route[2] | ~route_on | ~dev_int) ? 4'h0 :
    4'h1 << f_route[1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_pins <= '{level: 5'h00, oe_n: 5'h1f};
      host_supply_5v <= 1'b0;
      aux_supply_3v3 <= 1'b0;
      serirq_include_int <= 1'b0;
      pci_int_n <= 4'hf;
      video_activity <= 1'b0;
      socket_led <= 1'b0;
      sclk_en_out <= 1'b0;
      sclk_en_oe_n <= 1'b1;
      diag_test <= 13'h0000;
    end else begin
      mf_pins <= '{level: next_pin_level, oe_n: next_pin_oe_n};
      host_supply_5v <= f_host_5v;
      aux_supply_3v3 <= f_aux_3v3;
      serirq_include_int <= f_incl_int & serirq_enable;
      pci_int_n <= ~route_hot;
      video_activity <= f_video_en & video_busy;
      socket_led <= f_skt_en & socket_busy;
      sclk_en_out <= f_sclk_dir & sclk_en_drive;
      sclk_en_oe_n <= ~f_sclk_dir;
      diag_test <= f_diag;
    end
  end

  // ----------------------------------------------------------------
  // Command strobe width generator
  // ----------------------------------------------------------------
  // Width from field
  wire cmd_go = cmd_start & (cmd_count == 5'h00);
  wire [4:0] next_cmd_count = cmd_go ? gmcr_width_cycles(f_cmd_width) :
    (cmd_count != 5'h00) ? cmd_count - 5'h01 : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_count <= 5'h00;
      cmd_strobe <= 1'b0;
    end else begin
      cmd_count <= next_cmd_count;
      cmd_strobe <= next_cmd_count != 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RSV_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready & ~pwrite & psel & sel_ctrl1 |-> prdata[31:24] == 8'h00 &&
      prdata[21:20] == 2'b00 && prdata[7:0] == 8'h00)
    else $error("reserved bits read non-zero");

  AST_PIN5: assert property (
    @(posedge pclk) disable iff (!presetn)
    mf_is_output[4] |=> mf_pins.level[4] == $past(gpo[4]) &&
      !mf_pins.oe_n[4])
    else $error("pin 5 not driven by output bit 4");

  AST_PIN4: assert property (
    @(posedge pclk) disable iff (!presetn)
    mf_is_output[3] |=> mf_pins.level[3] == $past(gpo[3]))
    else $error("pin 4 not driven by output bit 3");

  AST_PIN210: assert property (
    @(posedge pclk) disable iff (!presetn)
    &mf_is_output[2:0] |=> mf_pins.level[2:0] == $past(gpo[2:0]))
    else $error("pins 2..0 not driven by output bits");

  AST_SUPPLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 host_supply_5v == $past(ctrl1[23]))
    else $error("host supply flag mismatch");

  AST_AUX: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 aux_supply_3v3 == $past(ctrl1[22]))
    else $error("aux supply flag mismatch");

  AST_STROBE40: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_go && f_cmd_width == 2'b10 |=> cmd_strobe [*5] ##1 !cmd_strobe)
    else $error("40 ns strobe width wrong");

  AST_INCLUDE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl1[16] |=> !serirq_include_int)
    else $error("interrupt included while disabled");

  AST_ROUTE: assert property (
    @(posedge pclk) disable iff (!presetn)
    route_on && dev_int && f_route == 3'b011 |=> pci_int_n == 4'h7)
    else $error("route to line D wrong");

  AST_ROUTE_GATE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !serirq_enable || !int_via_serirq |=> pci_int_n == 4'hf)
    else $error("routing applied outside serial IRQ mode");

  AST_VIDEO: assert property (
    @(posedge pclk) disable iff (!presetn)
    !f_video_en |=> !video_activity)
    else $error("video activity while disabled");

  AST_LED: assert property (
    @(posedge pclk) disable iff (!presetn)
    !f_skt_en |=> !socket_led)
    else $error("socket LED while disabled");

  AST_SCLK_DIR: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 sclk_en_oe_n == !$past(ctrl2[13]))
    else $error("clock-enable direction wrong");

  AST_DIAG: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 diag_test == $past(ctrl2[12:0]))
    else $error("diagnostic bits not presented");

  AST_RELEASE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mf_is_output[0] |=> mf_pins.oe_n[0] && !mf_pins.level[0])
    else $error("unselected pin affected");

  AST_RESET: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ctrl1 == gmcr_pkg::GMCR_RST_CTRL1 &&
      gpo == gmcr_pkg::GMCR_RST_GPO && ctrl2 == gmcr_pkg::GMCR_RST_CTRL2)
    else $error("defaults not restored by reset");

  AST_UNMAPPED_WR: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel & penable & pwrite & pslverr |=> $stable(ctrl1) &&
      $stable(gpo) && $stable(ctrl2))
    else $error("unmapped write changed a register");

  AST_STROBE_IDLE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cmd_start && cmd_count == 5'h00 |=> !cmd_strobe)
    else $error("strobe without a start");

  AST_STROBE80: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_go && f_cmd_width == 2'h1 |=> cmd_strobe &&
      cmd_count == gmcr_pkg::GMCR_CMD_80_CYC)
    else $error("80 ns strobe length wrong");

  AST_STROBE165: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_go && f_cmd_width == 2'h0 |=> cmd_strobe &&
      cmd_count == gmcr_pkg::GMCR_CMD_165_CYC)
    else $error("165 ns strobe length wrong");

  AST_ROUTE_A: assert property (
    @(posedge pclk) disable iff (!presetn)
    route_on && dev_int && f_route == 3'h0 |=> pci_int_n == 4'he)
    else $error("route to line A wrong");

  AST_ROUTE_RSV: assert property (
    @(posedge pclk) disable iff (!presetn)
    f_route[2] |=> pci_int_n == 4'hf)
    else $error("reserved route code drove a line");

  AST_SCLK_IN: assert property (
    @(posedge pclk) disable iff (!presetn)
    !f_sclk_dir |=> sclk_en_oe_n && !sclk_en_out)
    else $error("clock-enable pin driven while input");

  COV_WRITE_CTRL1: cover property (
    @(posedge pclk) disable iff (!presetn) commit & sel_ctrl1);
  COV_READ_GPO: cover property (
    @(posedge pclk) disable iff (!presetn)
    pready & ~pwrite & sel_gpo);
  COV_ROUTE_C: cover property (
    @(posedge pclk) disable iff (!presetn) pci_int_n == 4'hb);
  COV_UNMAPPED: cover property (
    @(posedge pclk) disable iff (!presetn) pslverr);

endmodule
